/* File: common/relay_sel_pkg.sv */
// package: parameter map, selection codes and timing constants for the status output selector
package relay_sel_pkg;
  // ************************************************************
  // register word indexes (byte address bits 5:2)
  // ************************************************************
  localparam logic [3:0] ofs_output45_select      = 4'h0;
  localparam logic [3:0] ofs_output45_fullscale   = 4'h1;
  localparam logic [3:0] ofs_relay_one_select     = 4'h2;
  localparam logic [3:0] ofs_relay_two_select     = 4'h3;
  localparam logic [3:0] ofs_relay_one_cutin      = 4'h4;
  localparam logic [3:0] ofs_relay_one_cutout     = 4'h5;
  localparam logic [3:0] ofs_pulse_ref_fullscale  = 4'h6;
  localparam logic [3:0] ofs_pulse_feedback_fs    = 4'h7;
  localparam logic [3:0] ofs_bus_value_42         = 4'h8;
  localparam logic [3:0] ofs_bus_value_45         = 4'h9;
  localparam logic [3:0] ofs_control_word         = 4'ha;
  localparam logic [3:0] ofs_output_status        = 4'hb;
  // ************************************************************
  // reset values and limits
  // ************************************************************
  localparam logic [5:0]  rst_output45_select     = 6'h00;
  localparam logic [4:0]  rst_relay_one_select    = 5'h08;
  localparam logic [4:0]  rst_relay_two_select    = 5'h03;
  localparam logic [15:0] rst_output45_fullscale  = 16'h1388; // 5000 hz
  localparam logic [15:0] max_output45_fullscale  = 16'h7d00; // 32000 hz
  localparam logic [15:0] min_output45_fullscale  = 16'h0001;
  localparam logic [15:0] rst_pulse_ref_fullscale = 16'h1388; // 5000 hz
  localparam logic [15:0] rst_pulse_feedback_fs   = 16'h61a8; // 25000 hz
  localparam logic [15:0] min_pulse_fullscale     = 16'h0064; // 100 hz
  localparam logic [15:0] max_pulse_fullscale     = 16'hfde8; // 65000 hz
  localparam logic [15:0] max_pulse_ref_term17    = 16'h1388; // 5000 hz
  localparam logic [9:0]  rst_delay_seconds       = 10'h000;
  localparam logic [9:0]  max_delay_seconds       = 10'h258;  // 600 s
  localparam logic [9:0]  max_percent_tenths      = 10'h3e8;  // 100.0 %
  localparam logic [9:0]  rst_percent_tenths      = 10'h000;
  // ************************************************************
  // selection codes
  // ************************************************************
  localparam logic [5:0] last_digital_code        = 6'h1a;    // 26
  localparam logic [5:0] last_analog_code         = 6'h29;    // 41
  localparam logic [4:0] code_option_relay        = 5'h1b;
  localparam logic [4:0] code_supply_imbalance    = 5'h1c;
  localparam logic [4:0] code_control_word        = 5'h1d;
  localparam logic [4:0] code_fire_active         = 5'h1e;
  localparam logic [4:0] code_fire_bypass         = 5'h1f;
  localparam int         cw_bit_relay_one         = 11;
  localparam int         cw_bit_relay_two         = 12;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int         clk_mhz                  = 250;
  localparam int         tick_seconds             = 1;
  localparam int         cycles_per_second        = tick_seconds * clk_mhz * 1000000;
  typedef enum logic [1:0] {out_digital, out_current, out_pulse} out_mode_type;
endpackage : relay_sel_pkg

/* File: src/status_output_relay_selector.sv */
// status output selector: relay and terminal 45 drive logic with an avalon-mm parameter port
// How it works
// (RL1) codes 0..26 on terminal 45 make it a digital on/off output of the chosen condition.
// (RL2) codes 27..41 on terminal 45 make it an analog output in current or pulse form.
// (RL3) the terminal 45 pulse form is scaled by a full-scale setting from 1 hz, 5000 hz after reset.
// (RL4) relay codes 0..18 pick a drive state as the relay condition.
// (RL5) relay codes 19..26 pick a frequency, current, feedback or reference limit comparison.
// (RL6) relay codes 27..31 pick option relay, supply imbalance, control word, fire active, fire bypass.
// (RL7) under control-word drive relay 1 follows control bit 11 and relay 2 follows bit 12.
// (RL8) a bus timeout drops any relay that is held on by the control word.
// (RL9) a relay is on while its selected condition holds and off otherwise.
// (RL10) relay 1 turns on only after a cut-in delay of 0..600 s, zero after reset.
// (RL11) relay 1 turns off only after a separate cut-out delay of 0..600 s, zero after reset.
// (RL12) the pulse reference full scale spans 100..65000 hz, or up to 5000 hz on terminal 17.
// (RL13) the pulse feedback full scale spans 100..65000 hz, 25000 hz after reset.
// (RL14) the bus writes 0..100.0 % values for terminals 42 and 45, zero after reset, not shown locally.
// (RL15) a bus-controlled analog terminal outputs the most recently written percentage.
// (RL16) a relay 1 change that reverts before its delay ends leaves the relay as it was.
//
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
module status_output_relay_selector
  import relay_sel_pkg::*;
#(
  parameter int cycles_per_tick = relay_sel_pkg::cycles_per_second
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [18:0] drive_state,
  input  wire logic [7:0]  limit_flags,
  input  wire logic        option_relay,
  input  wire logic        supply_imbalance,
  input  wire logic        fire_active,
  input  wire logic        fire_bypass,
  input  wire logic        bus_timeout,
  input  wire logic        pulse_ref_on_term17,
  input  wire logic [9:0]  analog_source_tenths,
  output logic             relay_one,
  output logic             relay_two,
  output logic             output45_digital,
  output logic [1:0]       output45_mode,
  output logic [9:0]       output45_level_tenths,
  output logic [15:0]      output45_fullscale,
  output logic [15:0]      pulse_ref_fullscale,
  output logic [15:0]      pulse_feedback_fullscale,
  output logic [9:0]       output42_bus_tenths
);
  import relay_sel_pkg::*;
  // ************************************************************
  // parameter registers
  // ************************************************************
  logic [5:0]  sel45_ff,  nxt_sel45;
  logic [4:0]  sel1_ff,   nxt_sel1;
  logic [4:0]  sel2_ff,   nxt_sel2;
  logic [15:0] fs45_ff,   nxt_fs45;
  logic [15:0] fsref_ff,  nxt_fsref;
  logic [15:0] fsfb_ff,   nxt_fsfb;
  logic [9:0]  cutin_ff,  nxt_cutin;
  logic [9:0]  cutout_ff, nxt_cutout;
  logic [9:0]  bus42_ff,  nxt_bus42;
  logic [9:0]  bus45_ff,  nxt_bus45;
  logic [15:0] cw_ff,     nxt_cw;
  logic        ack_ff,    nxt_ack;
  logic [31:0] rdata_ff,  nxt_rdata;
  logic [3:0]  idx;
  logic [15:0] wv;
  logic [9:0]  wp;
  logic [15:0] ref_top;
  logic        relay_one_ff, nxt_relay_one;
  logic        relay_two_ff, nxt_relay_two;

  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp16

  // one cycle of wait per access keeps read data registered
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign idx             = avs_address[5:2];
  assign wv              = (avs_writedata[31:16] != 16'h0000) ? 16'hffff : avs_writedata[15:0];
  assign wp              = (avs_writedata > 32'(max_percent_tenths)) ? max_percent_tenths : avs_writedata[9:0];
  assign ref_top         = pulse_ref_on_term17 ? max_pulse_ref_term17 : max_pulse_fullscale; // RL12

  always_comb begin
    nxt_sel45  = sel45_ff;
    nxt_sel1   = sel1_ff;
    nxt_sel2   = sel2_ff;
    nxt_fs45   = fs45_ff;
    nxt_fsref  = clamp16(fsref_ff, min_pulse_fullscale, ref_top); // RL12
    nxt_fsfb   = fsfb_ff;
    nxt_cutin  = cutin_ff;
    nxt_cutout = cutout_ff;
    nxt_bus42  = bus42_ff;
    nxt_bus45  = bus45_ff;
    nxt_cw     = cw_ff;
    nxt_ack    = (avs_read | avs_write) & ~ack_ff;
    nxt_rdata  = rdata_ff;
    // writes land on the edge that ends the wait, the same edge the master sees
    if (avs_write && ack_ff) begin
      if (idx == ofs_output45_select) begin
        nxt_sel45 = (avs_writedata > 32'(last_analog_code)) ? sel45_ff : avs_writedata[5:0];
      end else if (idx == ofs_output45_fullscale) begin
        nxt_fs45 = clamp16(wv, min_output45_fullscale, max_output45_fullscale); // RL3
      end else if (idx == ofs_relay_one_select) begin
        nxt_sel1 = avs_writedata[4:0];
      end else if (idx == ofs_relay_two_select) begin
        nxt_sel2 = avs_writedata[4:0];
      end else if (idx == ofs_relay_one_cutin) begin
        nxt_cutin = (avs_writedata > 32'(max_delay_seconds)) ? max_delay_seconds : avs_writedata[9:0]; // RL10
      end else if (idx == ofs_relay_one_cutout) begin
        nxt_cutout = (avs_writedata > 32'(max_delay_seconds)) ? max_delay_seconds : avs_writedata[9:0]; // RL11
      end else if (idx == ofs_pulse_ref_fullscale) begin
        nxt_fsref = clamp16(wv, min_pulse_fullscale, ref_top); // RL12
      end else if (idx == ofs_pulse_feedback_fs) begin
        nxt_fsfb = clamp16(wv, min_pulse_fullscale, max_pulse_fullscale); // RL13
      end else if (idx == ofs_bus_value_42) begin
        nxt_bus42 = wp; // RL14
      end else if (idx == ofs_bus_value_45) begin
        nxt_bus45 = wp; // RL14
      end else if (idx == ofs_control_word) begin
        nxt_cw = avs_writedata[15:0]; // RL7
      end
    end
    if (avs_read && !ack_ff) begin
      nxt_rdata = 32'h0;
      if (idx == ofs_output45_select) begin
        nxt_rdata[5:0] = sel45_ff;
      end else if (idx == ofs_output45_fullscale) begin
        nxt_rdata[15:0] = fs45_ff;
      end else if (idx == ofs_relay_one_select) begin
        nxt_rdata[4:0] = sel1_ff;
      end else if (idx == ofs_relay_two_select) begin
        nxt_rdata[4:0] = sel2_ff;
      end else if (idx == ofs_relay_one_cutin) begin
        nxt_rdata[9:0] = cutin_ff;
      end else if (idx == ofs_relay_one_cutout) begin
        nxt_rdata[9:0] = cutout_ff;
      end else if (idx == ofs_pulse_ref_fullscale) begin
        nxt_rdata[15:0] = fsref_ff;
      end else if (idx == ofs_pulse_feedback_fs) begin
        nxt_rdata[15:0] = fsfb_ff;
      end else if (idx == ofs_bus_value_42) begin
        nxt_rdata[9:0] = bus42_ff;
      end else if (idx == ofs_bus_value_45) begin
        nxt_rdata[9:0] = bus45_ff;
      end else if (idx == ofs_control_word) begin
        nxt_rdata[15:0] = cw_ff;
      end else if (idx == ofs_output_status) begin
        nxt_rdata[2:0] = {output45_digital, relay_two_ff, relay_one_ff};
      end
    end
    // a timeout drops bits 11 and 12 so control-word relays fall off until rewritten
    if (bus_timeout) begin
      nxt_cw[cw_bit_relay_one] = 1'b0; // RL8
      nxt_cw[cw_bit_relay_two] = 1'b0; // RL8
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel45_ff  <= rst_output45_select;
      sel1_ff   <= rst_relay_one_select;
      sel2_ff   <= rst_relay_two_select;
      fs45_ff   <= rst_output45_fullscale;
      fsref_ff  <= rst_pulse_ref_fullscale;
      fsfb_ff   <= rst_pulse_feedback_fs;
      cutin_ff  <= rst_delay_seconds;
      cutout_ff <= rst_delay_seconds;
      bus42_ff  <= rst_percent_tenths;
      bus45_ff  <= rst_percent_tenths;
      cw_ff     <= 16'h0000;
      ack_ff    <= 1'b0;
      rdata_ff  <= 32'h0;
    end else begin
      sel45_ff  <= nxt_sel45;
      sel1_ff   <= nxt_sel1;
      sel2_ff   <= nxt_sel2;
      fs45_ff   <= nxt_fs45;
      fsref_ff  <= nxt_fsref;
      fsfb_ff   <= nxt_fsfb;
      cutin_ff  <= nxt_cutin;
      cutout_ff <= nxt_cutout;
      bus42_ff  <= nxt_bus42;
      bus45_ff  <= nxt_bus45;
      cw_ff     <= nxt_cw;
      ack_ff    <= nxt_ack;
      rdata_ff  <= nxt_rdata;
    end
  end
  assign avs_readdata = rdata_ff;

  // ************************************************************
  // condition selection
  // ************************************************************
  function automatic logic pick(input logic [4:0] code, input logic cw_bit);
    if (code <= 5'd18) begin
      pick = drive_state[code]; // RL4
    end else if (code <= 5'd26) begin
      pick = limit_flags[3'(code - 5'd19)]; // RL5
    end else if (code == code_option_relay) begin
      pick = option_relay; // RL6
    end else if (code == code_supply_imbalance) begin
      pick = supply_imbalance; // RL6
    end else if (code == code_control_word) begin
      pick = cw_bit & ~bus_timeout; // RL7 RL8
    end else if (code == code_fire_active) begin
      pick = fire_active; // RL6
    end else begin
      pick = fire_bypass; // RL6
    end
  endfunction : pick

  logic cond_one, cond_two;
  always_comb begin
    cond_one = pick(sel1_ff, cw_ff[cw_bit_relay_one]);
    cond_two = pick(sel2_ff, cw_ff[cw_bit_relay_two]);
  end

  // ************************************************************
  // second tick and relay 1 delay
  // ************************************************************
  logic [31:0] tick_cnt_ff, nxt_tick_cnt;
  logic [9:0]  delay_cnt_ff, nxt_delay_cnt;
  logic        tick;
  assign tick = (tick_cnt_ff == 32'(cycles_per_tick - 1));

  always_comb begin
    nxt_tick_cnt  = tick ? 32'h0 : tick_cnt_ff + 32'h1;
    nxt_relay_one = relay_one_ff;
    nxt_delay_cnt = delay_cnt_ff;
    nxt_relay_two = cond_two; // RL9
    if (cond_one == relay_one_ff) begin
      nxt_delay_cnt = 10'h0; // RL16
    end else if (bus_timeout && sel1_ff == code_control_word) begin
      nxt_relay_one = 1'b0; // RL8
      nxt_delay_cnt = 10'h0;
    end else if (delay_cnt_ff >= (cond_one ? cutin_ff : cutout_ff)) begin
      nxt_relay_one = cond_one; // RL9 RL10 RL11
      nxt_delay_cnt = 10'h0;
    end else if (tick) begin
      nxt_delay_cnt = delay_cnt_ff + 10'h1; // RL16
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_ff  <= 32'h0;
      delay_cnt_ff <= 10'h0;
      relay_one_ff <= 1'b0;
      relay_two_ff <= 1'b0;
    end else begin
      tick_cnt_ff  <= nxt_tick_cnt;
      delay_cnt_ff <= nxt_delay_cnt;
      relay_one_ff <= nxt_relay_one;
      relay_two_ff <= nxt_relay_two;
    end
  end
  assign relay_one = relay_one_ff;
  assign relay_two = relay_two_ff;

  // ************************************************************
  // terminal 45 output
  // ************************************************************
  logic       dig45_ff;
  logic [1:0] mode45_ff;
  logic [9:0] lvl45_ff;
  logic [9:0] bus42_out_ff;
  logic       nxt_dig45;
  logic [1:0] nxt_mode45;
  logic [9:0] nxt_lvl45;
  logic [3:0] a_off;

  // analog codes come in triples: current 0-20, current 4-20, pulse; the last triple is bus driven
  assign a_off = 4'(sel45_ff - 6'd27);

  always_comb begin
    nxt_dig45  = 1'b0;
    nxt_mode45 = 2'(out_digital);
    nxt_lvl45  = 10'h0;
    if (sel45_ff <= last_digital_code) begin
      nxt_dig45 = pick(sel45_ff[4:0], 1'b0); // RL1
    end else begin
      nxt_mode45 = (a_off % 4'd3 == 4'd2) ? 2'(out_pulse) : 2'(out_current); // RL2
      nxt_lvl45  = (a_off >= 4'd12) ? bus45_ff : analog_source_tenths; // RL15
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dig45_ff     <= 1'b0;
      mode45_ff    <= 2'(out_digital);
      lvl45_ff     <= 10'h0;
      bus42_out_ff <= 10'h0;
    end else begin
      dig45_ff     <= nxt_dig45;
      mode45_ff    <= nxt_mode45;
      lvl45_ff     <= nxt_lvl45;
      bus42_out_ff <= bus42_ff; // RL15
    end
  end
  assign output45_digital         = dig45_ff;
  assign output45_mode            = mode45_ff;
  assign output45_level_tenths    = lvl45_ff;
  assign output45_fullscale       = fs45_ff; // RL3
  assign pulse_ref_fullscale      = fsref_ff;
  assign pulse_feedback_fullscale = fsfb_ff;
  assign output42_bus_tenths      = bus42_out_ff;

  // ************************************************************
  // checks
  // ************************************************************
  relay_two_follow_a: assert property (@(posedge clk) disable iff (rst)
    ##1 relay_two == $past(cond_two)) else $error("relay 2 not following condition"); // RL9
  timeout_drop_a: assert property (@(posedge clk) disable iff (rst)
    bus_timeout && sel2_ff == code_control_word |=> !relay_two) else $error("relay 2 held after timeout"); // RL8
  zero_delay_a: assert property (@(posedge clk) disable iff (rst)
    cutin_ff == 10'h0 && cond_one && !relay_one && !bus_timeout |=> relay_one) else $error("no-delay cut-in late"); // RL10
  cutout_hold_a: assert property (@(posedge clk) disable iff (rst)
    relay_one && !cond_one && delay_cnt_ff < cutout_ff && !bus_timeout |=> relay_one)
    else $error("cut-out too early"); // RL11
  revert_hold_a: assert property (@(posedge clk) disable iff (rst)
    cond_one == relay_one |=> relay_one == $past(relay_one)) else $error("relay 1 moved without cause"); // RL16
  digital45_a: assert property (@(posedge clk) disable iff (rst)
    sel45_ff > last_digital_code |=> !output45_digital) else $error("digital drive in analog mode"); // RL1
  analog45_a: assert property (@(posedge clk) disable iff (rst)
    sel45_ff > last_digital_code && $stable(sel45_ff) |=> output45_mode != 2'(out_digital))
    else $error("analog mode missing"); // RL2
  fs45_range_a: assert property (@(posedge clk) disable iff (rst)
    fs45_ff >= min_output45_fullscale && fs45_ff <= max_output45_fullscale) else $error("scale out of range"); // RL3
  fb_range_a: assert property (@(posedge clk) disable iff (rst)
    fsfb_ff >= min_pulse_fullscale && fsfb_ff <= max_pulse_fullscale) else $error("feedback scale out of range"); // RL13
  bus_pct_a: assert property (@(posedge clk) disable iff (rst)
    bus42_ff <= max_percent_tenths && bus45_ff <= max_percent_tenths) else $error("percent above full"); // RL14
endmodule : status_output_relay_selector
`default_nettype wire

/* File: tb/relay_load_model.sv */
// relay load model: counts coil pick-ups of both relay contacts
`timescale 1ns/1ns
`default_nettype none
module relay_load_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       relay_one,
  input  wire logic       relay_two,
  output logic      [7:0] one_pickups,
  output logic      [7:0] two_pickups
);
  logic [1:0] last_ff;
  // a coil only sees sampled levels, so a glitch inside one cycle is not counted
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_ff     <= 2'h0;
      one_pickups <= 8'h00;
      two_pickups <= 8'h00;
    end else begin
      last_ff <= {relay_two, relay_one};
      if (relay_one && !last_ff[0]) one_pickups <= one_pickups + 8'h01;
      if (relay_two && !last_ff[1]) two_pickups <= two_pickups + 8'h01;
    end
  end
endmodule : relay_load_model
`default_nettype wire

/* File: tb/tb_status_output_relay_selector.sv */
// testbench: relay and terminal 45 selector checks over the parameter port
`timescale 1ns/1ns
`default_nettype none
module tb_status_output_relay_selector;
  import relay_sel_pkg::*;
  typedef struct {logic [4:0] code; logic [18:0] ds; logic [7:0] lf; logic [3:0] misc; logic exp;} row_type;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [18:0] drive_state = 19'h0;
  logic [7:0]  limit_flags = 8'h00;
  logic [3:0]  misc = 4'h0;
  logic        bus_timeout = 1'b0;
  logic        term17 = 1'b0;
  logic [9:0]  analog_src = 10'h123;
  logic        relay_one, relay_two, output45_digital;
  logic [1:0]  output45_mode;
  logic [9:0]  level45, bus42;
  logic [15:0] fs45, fs_ref, fs_fb;
  logic [7:0]  pickups, pk, pickups2;
  logic [31:0] rd;
  int          errors = 0;
  int          n_checks = 0;
  int          n;
  row_type     rows[32];
  logic [31:0] rst_exp[11];
  logic [3:0]  cl_idx[6];
  logic [31:0] cl_val[6];
  logic [31:0] cl_exp[6];

  always #2 clk = ~clk;

  status_output_relay_selector #(.cycles_per_tick(10)) i_dut (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .drive_state(drive_state), .limit_flags(limit_flags), .option_relay(misc[0]), .supply_imbalance(misc[1]),
    .fire_active(misc[2]), .fire_bypass(misc[3]), .bus_timeout(bus_timeout), .pulse_ref_on_term17(term17),
    .analog_source_tenths(analog_src), .relay_one(relay_one), .relay_two(relay_two),
    .output45_digital(output45_digital), .output45_mode(output45_mode), .output45_level_tenths(level45),
    .output45_fullscale(fs45), .pulse_ref_fullscale(fs_ref), .pulse_feedback_fullscale(fs_fb),
    .output42_bus_tenths(bus42));

  relay_load_model i_load (.clk(clk), .rst(rst), .relay_one(relay_one), .relay_two(relay_two),
    .one_pickups(pickups), .two_pickups(pickups2));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one avalon transfer; the request stands until waitrequest is sampled low
  task automatic bus(input logic we, input logic [3:0] idx, input logic [31:0] wd);
    @(posedge clk);
    avs_address   <= {idx, 2'b00};
    avs_read      <= ~we;
    avs_write     <= we;
    avs_writedata <= wd;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic settle(input int cyc);
    repeat (cyc) @(posedge clk);
    #1;
  endtask : settle

  function automatic logic [31:0] pick(input logic [3:0] idx);
    case (idx)
      4'h1:    return 32'(fs45);
      4'h6:    return 32'(fs_ref);
      4'h7:    return 32'(fs_fb);
      default: return 32'(bus42);
    endcase
  endfunction : pick

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // the whole run is under a thousand cycles; this limit of 50000 cycles is far beyond it
  initial begin
    #200000;
    errors++;
    close_out();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    rst_exp = '{32'(rst_output45_select), 32'(rst_output45_fullscale), 32'(rst_relay_one_select),
      32'(rst_relay_two_select), 32'(rst_delay_seconds), 32'(rst_delay_seconds), 32'(rst_pulse_ref_fullscale),
      32'(rst_pulse_feedback_fs), 32'h0, 32'h0, 32'h0};
    cl_idx = '{4'h1, 4'h1, 4'h6, 4'h6, 4'h7, 4'h8};
    cl_val = '{32'h0, 32'h9c40, 32'h32, 32'h1770, 32'h11170, 32'h7d0};
    cl_exp = '{32'h1, 32'h7d00, 32'h64, 32'h1388, 32'hfde8, 32'h3e8};
    for (int c = 0; c < 32; c++) begin
      rows[c].code = 5'(c);
      rows[c].ds   = (c > 0 && c < 19) ? 19'h1 << c : 19'h0;
      rows[c].lf   = (c > 18 && c < 27) ? 8'h01 << (c - 19) : 8'h00;
      rows[c].misc = (c == 27) ? 4'h1 : (c == 28) ? 4'h2 : (c == 30) ? 4'h4 : (c == 31) ? 4'h8 : 4'h0;
      rows[c].exp  = (c != 0 && c != 29);
    end
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 11; i++) begin
      bus(1'b0, 4'(i), 32'h0);
      chk(rd, rst_exp[i]);
    end
    chk({fs45, fs_ref}, {rst_output45_fullscale, rst_pulse_ref_fullscale});
    chk(32'(fs_fb), 32'(rst_pulse_feedback_fs));
    foreach (rows[r]) begin
      bus(1'b1, 4'h2, 32'(rows[r].code));
      bus(1'b1, 4'h3, 32'(rows[r].code));
      if (r < 27) bus(1'b1, 4'h0, 32'(rows[r].code));
      @(posedge clk);
      drive_state <= rows[r].ds;
      limit_flags <= rows[r].lf;
      misc        <= rows[r].misc;
      settle(2);
      chk({relay_one, relay_two}, {2{rows[r].exp}});
      if (r < 27) chk({output45_digital, output45_mode}, {rows[r].exp, 2'(out_digital)});
      @(posedge clk);
      drive_state <= 19'h0;
      limit_flags <= 8'h00;
      misc        <= 4'h0;
      settle(2);
      chk({relay_one, relay_two}, 32'h0);
    end
    chk(32'(pickups2), 32'h1e);
    // ************************************************************
    // analog forms, refused select, clamps
    // ************************************************************
    bus(1'b1, 4'h9, 32'h1f4);
    for (int c = 27; c < 42; c++) begin
      bus(1'b1, 4'h0, 32'(c));
      settle(2);
      chk(32'(output45_mode), ((c - 27) % 3 == 2) ? 32'(out_pulse) : 32'(out_current));
      chk(32'(level45), (c > 38) ? 32'h1f4 : 32'(analog_src));
    end
    bus(1'b1, 4'h0, 32'h2a);
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h29);
    @(posedge clk);
    term17 <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, cl_idx[i], cl_val[i]);
      settle(2);
      chk(pick(cl_idx[i]), cl_exp[i]);
    end
    // ************************************************************
    // relay 1 delays: 2 ticks in, 3 ticks out, 10 cycles a tick
    // ************************************************************
    bus(1'b1, 4'h2, 32'h3);
    bus(1'b1, 4'h4, 32'h2);
    bus(1'b1, 4'h5, 32'h3);
    pk = pickups;
    @(posedge clk);
    drive_state <= 19'h8;
    repeat (5) @(posedge clk);
    drive_state <= 19'h0;
    settle(40);
    chk({relay_one, pickups}, {1'b0, pk});
    @(posedge clk);
    drive_state <= 19'h8;
    n = 0;
    while (relay_one !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n > 10 && n < 34), 32'h1);
    drive_state <= 19'h0;
    n = 0;
    while (relay_one !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n > 20 && n < 44), 32'h1);
    // ************************************************************
    // control word drive and bus timeout
    // ************************************************************
    bus(1'b1, 4'h4, 32'h0);
    bus(1'b1, 4'h2, 32'h1d);
    bus(1'b1, 4'h3, 32'h1d);
    bus(1'b1, 4'ha, 32'h1800);
    settle(2);
    chk({relay_one, relay_two}, 32'h3);
    bus(1'b0, 4'hb, 32'h0);
    chk(rd[1:0], 32'h3);
    @(posedge clk);
    bus_timeout <= 1'b1;
    settle(2);
    chk({relay_one, relay_two}, 32'h0);
    @(posedge clk);
    bus_timeout <= 1'b0;
    bus(1'b0, 4'ha, 32'h0);
    chk(rd[12:11], 32'h0);
    bus(1'b1, 4'hb, 32'h7);
    bus(1'b0, 4'hb, 32'h0);
    chk(rd[1:0], 32'h0);
    bus(1'b1, 4'hf, 32'hffff);
    bus(1'b0, 4'hf, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 4'ha, 32'h0800);
    settle(2);
    chk({relay_one, relay_two}, 32'h2);
    // second reset in mid-run
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    settle(1);
    chk(32'(relay_one), 32'h0);
    bus(1'b0, 4'h3, 32'h0);
    chk(rd, 32'(rst_relay_two_select));
    close_out();
  end
endmodule : tb_status_output_relay_selector
`default_nettype wire
